// ===== hdl/sms_pkg.sv
// shared constants and types of the deep-sleep standby controller
package sms_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int HOLD_TIME_NS = 5000;
  localparam int HOLD_CYCLES = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_W = 7;
  localparam int SETTLE_W = 16;
  localparam int SETTLE_SEL_MAX = 4;

  localparam logic [1:0] IDX_CTRL = 2'h0;
  localparam logic [1:0] IDX_CLKSEL = 2'h1;
  localparam logic [1:0] IDX_STATUS = 2'h2;

  localparam int CTRL_SETTLE_LSB = 0;
  localparam int CTRL_AMP = 3;
  localparam int CTRL_LSRUN = 4;
  localparam int CTRL_W = 5;
  localparam logic [4:0] CTRL_RESET = 5'h10;

  localparam int CSEL_TA_EXT = 0;
  localparam int CSEL_TB_EXT = 1;
  localparam int CSEL_AUX_LSB = 2;
  localparam int CSEL_ASYNC_TA = 5;
  localparam int CSEL_CSP_EXT = 6;
  localparam int CSEL_W = 7;
  localparam logic [6:0] CSEL_RESET = 7'h00;

  localparam logic [2:0] AUX_LS = 3'h0;
  localparam logic [2:0] AUX_LS_DIV7 = 3'h1;
  localparam logic [2:0] AUX_LS_DIV9 = 3'h2;

  localparam logic [1:0] SRC_FAST = 2'h0;
  localparam logic [1:0] SRC_CRYSTAL = 2'h1;
  localparam logic [1:0] SRC_EXTMAIN = 2'h2;

  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_LIGHT = 4'b0010,
    ST_DEEP = 4'b0100,
    ST_SETTLE = 4'b1000
  } sms_state_e;
endpackage

// ===== hdl/sms_wait_timer.sv
// down counter for the oscillation stabilization wait
`timescale 1ns/1ps
`default_nettype none
module sms_wait_timer #(
  parameter int Width = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  input wire logic [Width-1:0] loadVal,
  output logic expired
);
  logic [Width-1:0] cnt_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (start) begin
      cnt_q <= loadVal;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign expired = (cnt_q == '0);
endmodule // sms_wait_timer
`default_nettype wire

// ===== hdl/sms_ctrl.sv
// deep-sleep standby controller with avalon register slave
//
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Function
// - enter only by stop instruction on main clock
// - pending unmasked request drops to light-sleep
// - deep-sleep cuts cpu clock and main oscillators
// - keep ram, port latches, low-speed oscillator state
// - regulators go low-current in deep-sleep
// - 8-bit counters run only on external input
// - aux timer runs only on low-speed selections
// - watchdog runs unless low-speed oscillator stopped
// - stop never halts low-speed oscillator itself
// - async serial runs only from external-clocked timer
// - clocked serial port runs only on external clock
// - amplifier gain withholds clock five microseconds on fast or external main source
// - unmasked request wakes, then vector or next
// - only interrupt or reset ends deep-sleep
// - reset ends deep-sleep, restarts at reset vector
module sms_ctrl #(
  parameter int NumIrq = 8,
  parameter int SettleUnitCycles = 256
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic stopExec,
  input wire logic cpuOnMainClk,
  input wire logic [1:0] cpuClkSrc,
  input wire logic [NumIrq-1:0] irqReqFlags,
  input wire logic [NumIrq-1:0] irqMaskFlags,
  input wire logic intAckEnable,
  input wire logic lsOscStoppableOpt,
  output logic cpuClkEn,
  output logic mainOscEn,
  output logic extClkInEn,
  output logic pllEn,
  output logic flashEn,
  output logic timer16En,
  output logic usbEn,
  output logic regLowCurrent,
  output logic retainHold,
  output logic timerAEn,
  output logic timerBEn,
  output logic auxTimerEn,
  output logic wdtClkEn,
  output logic lowSpeedOscEn,
  output logic asyncSerialEn,
  output logic clockedSerialEn,
  output logic supervisorEn,
  output logic takeVector,
  output logic resumeNext,
  output logic resetVectorStart
);
  // the unit shifted by the clamped select must still fit the settle counter
  if (NumIrq < 1 || SettleUnitCycles < 1 || SettleUnitCycles > 4095) begin : g_bad_param
    $error("sms_ctrl: NumIrq or SettleUnitCycles out of range");
  end

  sms_pkg::sms_state_e state_q, state_d;
  logic [sms_pkg::CTRL_W-1:0] ctrl_q;
  logic [sms_pkg::CSEL_W-1:0] csel_q;
  logic waitReq_q;
  logic [31:0] rdata_q;
  logic optStop_q, firstCycle_q, lastWakeInt_q, lastLight_q, ampHold_q;
  logic [sms_pkg::HOLD_W-1:0] holdCnt_q;
  logic [7:0] sinceRel_q;
  logic pending, stopGo, timerStart, timerExpired, exitWake, ampCond;
  logic [sms_pkg::SETTLE_W-1:0] settleLoad;
  logic [2:0] auxSel;
  logic deepNext;

  function automatic logic [sms_pkg::SETTLE_W-1:0] settleCycles(input logic [2:0] sel);
    logic [2:0] s;
    s = (sel > 3'(sms_pkg::SETTLE_SEL_MAX)) ? 3'(sms_pkg::SETTLE_SEL_MAX) : sel;
    settleCycles = sms_pkg::SETTLE_W'(SettleUnitCycles) << s;
  endfunction

  assign pending = |(irqReqFlags & ~irqMaskFlags);
  assign stopGo = stopExec && cpuOnMainClk;
  assign ampCond = ctrl_q[sms_pkg::CTRL_AMP] &&
    (cpuClkSrc == sms_pkg::SRC_FAST || cpuClkSrc == sms_pkg::SRC_EXTMAIN);
  assign auxSel = csel_q[sms_pkg::CSEL_AUX_LSB +: 3];
  assign settleLoad = settleCycles(ctrl_q[sms_pkg::CTRL_SETTLE_LSB +: 3]);
  assign timerStart = (state_q == sms_pkg::ST_RUN && stopGo && pending) ||
    (state_q == sms_pkg::ST_DEEP && pending);
  assign exitWake = state_q != sms_pkg::ST_RUN && state_d == sms_pkg::ST_RUN;
  assign deepNext = (state_d == sms_pkg::ST_DEEP);

  sms_wait_timer #(.Width(sms_pkg::SETTLE_W)) u_wait (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(timerStart),
    .loadVal(settleLoad),
    .expired(timerExpired)
  );

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      sms_pkg::ST_RUN: begin
        if (stopGo) begin
          state_d = pending ? sms_pkg::ST_LIGHT : sms_pkg::ST_DEEP;
        end
      end
      sms_pkg::ST_LIGHT: begin
        if (timerExpired) begin
          state_d = sms_pkg::ST_RUN;
        end
      end
      sms_pkg::ST_DEEP: begin
        if (pending) begin
          state_d = sms_pkg::ST_SETTLE;
        end
      end
      sms_pkg::ST_SETTLE: begin
        if (timerExpired && holdCnt_q == '0) begin
          state_d = sms_pkg::ST_RUN;
        end
      end
      default: state_d = sms_pkg::ST_RUN;
    endcase
  end

  // reset overrides every state, deep-sleep included
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= sms_pkg::ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // the option is a strap, so it is caught on the first clock after release
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      firstCycle_q <= 1'b1;
      optStop_q <= 1'b0;
      resetVectorStart <= 1'b0;
    end else begin
      firstCycle_q <= 1'b0;
      resetVectorStart <= firstCycle_q;
      if (firstCycle_q) begin
        optStop_q <= lsOscStoppableOpt;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      holdCnt_q <= '0;
      ampHold_q <= 1'b0;
    end else if (state_q == sms_pkg::ST_DEEP && pending) begin
      holdCnt_q <= ampCond ? sms_pkg::HOLD_W'(sms_pkg::HOLD_CYCLES) : '0;
      ampHold_q <= ampCond;
    end else if (holdCnt_q != '0) begin
      holdCnt_q <= holdCnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      takeVector <= 1'b0;
      resumeNext <= 1'b0;
      lastWakeInt_q <= 1'b0;
      lastLight_q <= 1'b0;
    end else begin
      takeVector <= exitWake && intAckEnable;
      resumeNext <= exitWake && !intAckEnable;
      if (exitWake) begin
        lastWakeInt_q <= 1'b1;
        lastLight_q <= (state_q == sms_pkg::ST_LIGHT);
      end
    end
  end

  // enables follow the next state so they line up with state_q
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cpuClkEn <= 1'b1;
      mainOscEn <= 1'b1;
      extClkInEn <= 1'b1;
      pllEn <= 1'b1;
      flashEn <= 1'b1;
      timer16En <= 1'b1;
      usbEn <= 1'b1;
      regLowCurrent <= 1'b0;
      retainHold <= 1'b0;
    end else begin
      cpuClkEn <= (state_d == sms_pkg::ST_RUN);
      mainOscEn <= !deepNext;
      extClkInEn <= !deepNext;
      pllEn <= !deepNext;
      flashEn <= (state_d == sms_pkg::ST_RUN);
      timer16En <= !deepNext;
      usbEn <= !deepNext;
      regLowCurrent <= deepNext;
      retainHold <= (state_d != sms_pkg::ST_RUN);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timerAEn <= 1'b1;
      timerBEn <= 1'b1;
      auxTimerEn <= 1'b1;
      asyncSerialEn <= 1'b1;
      clockedSerialEn <= 1'b1;
    end else begin
      timerAEn <= !deepNext || csel_q[sms_pkg::CSEL_TA_EXT];
      timerBEn <= !deepNext || csel_q[sms_pkg::CSEL_TB_EXT];
      auxTimerEn <= !deepNext || auxSel == sms_pkg::AUX_LS ||
        auxSel == sms_pkg::AUX_LS_DIV7 || auxSel == sms_pkg::AUX_LS_DIV9;
      asyncSerialEn <= !deepNext ||
        (csel_q[sms_pkg::CSEL_ASYNC_TA] && csel_q[sms_pkg::CSEL_TA_EXT]);
      clockedSerialEn <= !deepNext || csel_q[sms_pkg::CSEL_CSP_EXT];
    end
  end

  // state changes never touch the low-speed oscillator, only the strap and software do
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lowSpeedOscEn <= 1'b1;
      wdtClkEn <= 1'b1;
      supervisorEn <= 1'b1;
    end else begin
      lowSpeedOscEn <= !optStop_q || ctrl_q[sms_pkg::CTRL_LSRUN];
      wdtClkEn <= !optStop_q || ctrl_q[sms_pkg::CTRL_LSRUN];
      supervisorEn <= 1'b1;
    end
  end

  // one wait cycle per access: waitrequest drops on the second cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      waitReq_q <= 1'b1;
      rdata_q <= '0;
    end else begin
      waitReq_q <= !((avs_read || avs_write) && waitReq_q);
      if (avs_read && waitReq_q) begin
        unique case (avs_address[3:2])
          sms_pkg::IDX_CTRL: rdata_q <= 32'(ctrl_q);
          sms_pkg::IDX_CLKSEL: rdata_q <= 32'(csel_q);
          sms_pkg::IDX_STATUS: rdata_q <= 32'({optStop_q, lastLight_q, lastWakeInt_q,
            1'b0, state_q});
          default: rdata_q <= '0;
        endcase
      end else begin
        rdata_q <= '0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= sms_pkg::CTRL_RESET;
      csel_q <= sms_pkg::CSEL_RESET;
    end else if (avs_write && !waitReq_q) begin
      if (avs_address[3:2] == sms_pkg::IDX_CTRL) begin
        ctrl_q <= avs_writedata[sms_pkg::CTRL_W-1:0];
      end
      if (avs_address[3:2] == sms_pkg::IDX_CLKSEL) begin
        csel_q <= avs_writedata[sms_pkg::CSEL_W-1:0];
      end
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = waitReq_q;

  always_ff @(posedge clk_sys) begin
    if (rst || state_q != sms_pkg::ST_SETTLE) begin
      sinceRel_q <= 8'h00;
    end else if (sinceRel_q != 8'hff) begin
      sinceRel_q <= sinceRel_q + 8'h01;
    end
  end

  a_entry_main_clk: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == sms_pkg::ST_RUN && stopExec && !cpuOnMainClk |=> state_q == sms_pkg::ST_RUN)
    else $error("stop entered off main clock");
  a_pending_light: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == sms_pkg::ST_RUN && stopGo && pending |=> state_q == sms_pkg::ST_LIGHT && cpuClkEn == 1'b0)
    else $error("pending request did not drop to light-sleep");
  a_deep_gating: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == sms_pkg::ST_DEEP |-> !cpuClkEn && !mainOscEn && !extClkInEn && !pllEn &&
    !flashEn && !timer16En && !usbEn)
    else $error("clock or block left running in deep-sleep");
  a_retain_state: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == sms_pkg::ST_DEEP && $past(state_q) == sms_pkg::ST_DEEP |->
    retainHold && $stable(lowSpeedOscEn))
    else $error("retention lost in deep-sleep");
  a_reg_lowcur: assert property (@(posedge clk_sys) disable iff (rst)
    regLowCurrent == (state_q == sms_pkg::ST_DEEP))
    else $error("regulator mode wrong");
  a_timer_ext: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == sms_pkg::ST_DEEP && $past(state_q) == sms_pkg::ST_DEEP |->
    timerAEn == $past(csel_q[sms_pkg::CSEL_TA_EXT]) && timerBEn == $past(csel_q[sms_pkg::CSEL_TB_EXT]))
    else $error("8-bit counter enable wrong in deep-sleep");
  a_aux_timer: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == sms_pkg::ST_DEEP && $past(state_q) == sms_pkg::ST_DEEP && $past(auxSel) > 3'h2
    |-> !auxTimerEn)
    else $error("aux timer runs on internal clock in deep-sleep");
  a_wdt_clock: assert property (@(posedge clk_sys) disable iff (rst || firstCycle_q)
    ##1 wdtClkEn == !($past(optStop_q) && !$past(ctrl_q[sms_pkg::CTRL_LSRUN])))
    else $error("watchdog clock feed wrong");
  a_stop_keeps_ls: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == sms_pkg::ST_RUN && stopGo && lowSpeedOscEn && $stable(ctrl_q) |=> lowSpeedOscEn)
    else $error("stop entry halted low-speed oscillator");
  a_async_serial: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == sms_pkg::ST_DEEP && asyncSerialEn |-> timerAEn)
    else $error("async serial runs without external-clocked timer");
  a_csp_extclk: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == sms_pkg::ST_DEEP && $past(state_q) == sms_pkg::ST_DEEP |->
    clockedSerialEn == $past(csel_q[sms_pkg::CSEL_CSP_EXT]))
    else $error("clocked serial enable wrong in deep-sleep");
  a_hold_5us: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == sms_pkg::ST_RUN && $past(state_q) == sms_pkg::ST_SETTLE && ampHold_q |->
    cpuClkEn && $past(sinceRel_q) >= 8'(sms_pkg::HOLD_CYCLES))
    else $error("cpu clock returned before hold time");
  a_wake_result: assert property (@(posedge clk_sys) disable iff (rst)
    exitWake |=> takeVector == $past(intAckEnable) && resumeNext == !$past(intAckEnable))
    else $error("wake did not choose vector or next");
  a_wake_only: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == sms_pkg::ST_DEEP && !pending |=> state_q == sms_pkg::ST_DEEP)
    else $error("deep-sleep left without request");
  a_reset_exit: assert property (@(posedge clk_sys)
    rst ##1 !rst |-> state_q == sms_pkg::ST_RUN ##1 resetVectorStart)
    else $error("reset did not restart from reset vector");
  a_supervisors: assert property (@(posedge clk_sys) disable iff (rst) supervisorEn)
    else $error("supervisory functions disabled");
endmodule // sms_ctrl
`default_nettype wire

// ===== dv/sms_cpu_model.sv
// stand-in for the cpu core and interrupt controller at the far side
`timescale 1ns/1ps
`default_nettype none
module sms_cpu_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cmdStop,
  input wire logic [7:0] cmdIrq,
  input wire logic takeVector,
  input wire logic resumeNext,
  output logic stopExec,
  output logic [7:0] irqReqFlags
);
  // the stop request is only ever the one-cycle trace of the stop instruction
  always_ff @(posedge clk_sys) begin
    if (rst) stopExec <= 1'b0;
    else stopExec <= cmdStop;
  end
  // a raised request stays up until serviced; dropping it early would hide a lost wake
  always_ff @(posedge clk_sys) begin
    if (rst) irqReqFlags <= 8'h00;
    else if (takeVector || resumeNext) irqReqFlags <= 8'h00;
    else irqReqFlags <= irqReqFlags | cmdIrq;
  end
endmodule // sms_cpu_model
`default_nettype wire

// ===== dv/stop_mode_standby_control_tb_top.sv
// self-checking bench of the deep-sleep standby controller
`timescale 1ns/1ps
`default_nettype none
module stop_mode_standby_control_tb_top;
  logic clk_sys, rst, avs_read, avs_write, avs_waitrequest, stopExec, cpuOnMainClk, cmdStop;
  logic intAckEnable, lsOscStoppableOpt, cpuClkEn, mainOscEn, extClkInEn, pllEn, flashEn;
  logic timer16En, usbEn, regLowCurrent, retainHold, timerAEn, timerBEn, auxTimerEn, wdtClkEn;
  logic lowSpeedOscEn, asyncSerialEn, clockedSerialEn, supervisorEn, takeVector, resumeNext;
  logic resetVectorStart;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [1:0] cpuClkSrc, p;
  logic [7:0] irqReqFlags, irqMaskFlags, cmdIrq;
  logic [6:0] tbl [7] = '{7'h00, 7'h07, 7'h2b, 7'h4e, 7'h7f, 7'h20, 7'h11};
  int n_fail = 0;
  int checks = 0;
  int n;
  // short settle unit keeps every settle wait to at most 32 cycles
  sms_ctrl #(.NumIrq(8), .SettleUnitCycles(2)) u_dut (.clk_sys, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .stopExec, .cpuOnMainClk,
    .cpuClkSrc, .irqReqFlags, .irqMaskFlags, .intAckEnable, .lsOscStoppableOpt, .cpuClkEn,
    .mainOscEn, .extClkInEn, .pllEn, .flashEn, .timer16En, .usbEn, .regLowCurrent, .retainHold,
    .timerAEn, .timerBEn, .auxTimerEn, .wdtClkEn, .lowSpeedOscEn, .asyncSerialEn,
    .clockedSerialEn, .supervisorEn, .takeVector, .resumeNext, .resetVectorStart);
  sms_cpu_model u_cpu (.clk_sys, .rst, .cmdStop, .cmdIrq, .takeVector, .resumeNext, .stopExec,
    .irqReqFlags);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  function automatic logic [9:0] grp();
    return {cpuClkEn, mainOscEn, extClkInEn, pllEn, flashEn, timer16En, usbEn, regLowCurrent,
      retainHold, supervisorEn};
  endfunction
  function automatic logic [4:0] want(input logic [6:0] c);
    return {c[0], c[1], c[4:2] <= 3'h2, c[5] & c[0], c[6]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t ns: saw %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (k == 50) n_fail++;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q & m, exp);
  endtask
  task automatic wait_rvs();
    int k;
    k = 0;
    while (resetVectorStart !== 1'b1 && k < 8) begin
      @(posedge clk_sys);
      k++;
    end
    check(32'(resetVectorStart), 32'h1);
  endtask
  task automatic do_stop();
    cmdStop <= 1'b1;
    @(posedge clk_sys);
    cmdStop <= 1'b0;
    tick(2);
  endtask
  task automatic wake(input logic [7:0] irq, output int k, output logic [1:0] pl);
    cmdIrq <= irq;
    @(posedge clk_sys);
    cmdIrq <= 8'h00;
    k = 0;
    while (cpuClkEn !== 1'b1 && k < 500) begin
      @(posedge clk_sys);
      k++;
    end
    // the wake pulse stands in the cycle the cpu clock comes back
    pl = {takeVector, resumeNext};
  endtask
  task automatic sleep(input logic [31:0] ctrl, input logic [6:0] csel, input logic ack,
                       output int k);
    logic [1:0] pl;
    wr(4'h0, ctrl);
    wr(4'h4, {25'h0, csel});
    intAckEnable <= ack;
    do_stop();
    check(32'(grp()), 32'(10'b0000000111));
    check(32'({timerAEn, timerBEn, auxTimerEn, asyncSerialEn, clockedSerialEn}), 32'(want(csel)));
    check(32'({lowSpeedOscEn, wdtClkEn}), 32'({2{ctrl[4]}}));
    rdc(4'h8, 32'h4, 32'hf);
    tick(20);
    check(32'(grp()), 32'(10'b0000000111));
    wake(8'h01, k, pl);
    check(32'({grp(), pl}), 32'({10'b1111111001, ack, !ack}));
  endtask
  task automatic tally_and_finish();
    if (n_fail == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // a hang anywhere still ends in a verdict
  initial begin
    #3000000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    rst = 1'b1;
    {avs_read, avs_write, cmdStop, intAckEnable} = 4'h0;
    {avs_address, avs_writedata, cmdIrq, irqMaskFlags, cpuClkSrc} = '0;
    cpuOnMainClk = 1'b1;
    lsOscStoppableOpt = 1'b1;
    tick(16);
    rst <= 1'b0;
    wait_rvs();
    check(32'(grp()), 32'(10'b1111111001));
    rdc(4'h0, 32'h10, 32'hffffffff);
    rdc(4'h4, 32'h0, 32'hffffffff);
    wr(4'hc, 32'hffffffff);
    rdc(4'hc, 32'h0, 32'hffffffff);
    wr(4'h4, 32'hffffffff);
    rdc(4'h4, 32'h7f, 32'hffffffff);
    for (int i = 0; i < 7; i++) begin
      sleep(i[0] ? 32'h10 : 32'h00, tbl[i], i[1], n);
    end
    // gain bit only holds the clock back on the fast or external main source
    for (int s = 0; s < 3; s++) begin
      cpuClkSrc <= 2'(s);
      sleep(32'h18, 7'h00, 1'b1, n);
      check(32'(n >= sms_pkg::HOLD_CYCLES), 32'(s != 1));
    end
    cpuClkSrc <= 2'h0;
    wr(4'h0, 32'h14);
    cmdIrq <= 8'h02;
    @(posedge clk_sys);
    cmdIrq <= 8'h00;
    do_stop();
    check(32'(grp()), 32'(10'b0111011011));
    rdc(4'h8, 32'h2, 32'hf);
    wake(8'h00, n, p);
    check(32'(p), 32'h2);
    rdc(4'h8, 32'he1, 32'hff);
    wr(4'h0, 32'h10);
    irqMaskFlags <= 8'h01;
    do_stop();
    cmdIrq <= 8'h01;
    @(posedge clk_sys);
    cmdIrq <= 8'h00;
    tick(20);
    check(32'(grp()), 32'(10'b0000000111));
    irqMaskFlags <= 8'h00;
    wake(8'h00, n, p);
    check(32'({grp(), p}), 32'({10'b1111111001, 2'b10}));
    cpuOnMainClk <= 1'b0;
    do_stop();
    check(32'(grp()), 32'(10'b1111111001));
    rdc(4'h8, 32'h1, 32'hf);
    cpuOnMainClk <= 1'b1;
    do_stop();
    rst <= 1'b1;
    lsOscStoppableOpt <= 1'b0;
    @(posedge clk_sys);
    rst <= 1'b0;
    wait_rvs();
    check(32'(grp()), 32'(10'b1111111001));
    // strap now forbids software stop, so the oscillator must keep running
    wr(4'h0, 32'h0);
    tick(1);
    check(32'({lowSpeedOscEn, wdtClkEn}), 32'h3);
    rdc(4'h8, 32'h01, 32'hff);
    tally_and_finish();
  end
endmodule // stop_mode_standby_control_tb_top
`default_nettype wire
